//--- common/gp_defs.svh
// Function
// - Eight-bit select mask, bit 0 is pin 0
// - Level read shows inputs and outputs alike
// - Unselected bits of level read are zero
// - Enable unmasks selected pins only
// - Disable masks selected pins only
// - Raw and masked status, view selector
// - Clear drops pending bits of selected pins
// - Request stays high until source cleared or disabled
// - Each pin carries one function at most
// - Analog type only prepares routed pins
// - Input, output or peripheral direction modes
// - Falling, rising, both, low, high detection
// - Analog pad type beside push-pull, open-drain
`ifndef GP_DEFS_SVH
`define GP_DEFS_SVH
// Byte offsets of the register map
`define GP_OFF_SEL      8'h00
`define GP_OFF_LEVEL    8'h04
`define GP_OFF_INT_EN   8'h08
`define GP_OFF_INT_DIS  8'h0C
`define GP_OFF_INT_CLR  8'h10
`define GP_OFF_INT_STAT 8'h14
`define GP_OFF_VIEW     8'h18
`define GP_OFF_DIR      8'h1C
`define GP_OFF_ITYPE    8'h20
`define GP_OFF_PAD      8'h24
`define GP_OFF_DOUT     8'h28
`define GP_OFF_MUX      8'h2C
// Field positions of the mux code
`define GP_MUX_PIN_LSB  0
`define GP_MUX_FUNC_LSB 4
// Reset values
`define GP_RST_BYTE     8'h00
`define GP_RST_FUNC     32'h0000_0000
`endif

//--- common/gp_pkg.sv
package gp_pkg;
    // Direction mode of one pin
    typedef enum logic [1:0] {GP_DIR_IN, GP_DIR_OUT, GP_DIR_HW} gp_dir_t;
    // Interrupt detection of one pin
    typedef enum logic [2:0] {GP_FALL, GP_RISE, GP_BOTH, GP_LOW, GP_HIGH} gp_itype_t;
    // Pad type of one pin
    typedef enum logic [1:0] {GP_PUSH_PULL, GP_OPEN_DRAIN, GP_ANALOG} gp_pad_t;
    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } gp_apb_req_t;
    // APB answer to the master
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } gp_apb_rsp_t;
endpackage : gp_pkg

//--- hdl/gp_port.sv
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "gp_defs.svh"
module gp_port (
    input  wire logic                clock,       // 100 MHz system clock
    input  wire logic                arst_n,      // Asynchronous reset, active low
    input  wire gp_pkg::gp_apb_req_t apb_req,     // APB request
    output var  gp_pkg::gp_apb_rsp_t apb_rsp,     // APB answer, registered
    input  wire logic [7:0]          pin_in,      // Pad levels, asynchronous
    output logic      [7:0]          pin_out,     // Pad output values
    output logic      [7:0]          pin_oe,      // Pad output enables, high drives
    input  wire logic [7:0]          periph_out,  // Peripheral output per pin
    input  wire logic [7:0]          periph_oe,   // Peripheral enable per pin
    output logic      [7:0]          periph_in,   // Synchronised levels to peripherals
    output logic      [31:0]         alt_func,    // Four-bit function code per pin
    output logic      [7:0]          analog_en,   // Pad in analog input type
    output logic                     irq          // Level interrupt request
);
    import gp_pkg::*;

    // Every check below runs on the one system clock and sleeps through reset
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    ////////////////////////////////////////////////////////////////////////////
    // State
    // Everything the port remembers lives in one struct, so reset and
    // register update stay in a single process
    typedef struct packed {
        logic [7:0]      sel;      // Pin select mask
        logic [7:0]      unmask;   // Interrupt unmask per pin
        logic [7:0]      raw;      // Raw pending interrupts
        logic            view;     // Masked view select for status reads
        gp_dir_t   [7:0] dir;      // Direction mode per pin
        gp_itype_t [7:0] itype;    // Detection type per pin
        gp_pad_t   [7:0] pad;      // Pad type per pin
        logic [7:0]      aen;      // Analog pad flag per pin, for the output
        logic [7:0]      dout;     // Software output data
        logic [31:0]     func;     // Function code per pin
        logic [7:0]      sync1;    // First synchroniser stage
        logic [7:0]      sync2;    // Second synchroniser stage
        logic [7:0]      prev;     // Previous level for edge detection
        logic [7:0]      pout;     // Registered pad value
        logic [7:0]      poe;      // Registered pad enable
        logic            irq;      // Registered request
        gp_apb_rsp_t     rsp;      // Registered bus answer
    } gp_state_t;

    gp_state_t   s;       // Present state
    gp_state_t   next_s;  // Next state
    logic [7:0]  ev;      // Detected events this cycle
    logic [7:0]  clr;     // Pins cleared this cycle
    logic        wr_acc;  // Write completes at this edge
    logic        rd_req;  // Access answered at this edge, read or write
    logic        hit;     // Address maps to a register
    logic [31:0] rdval;   // Read mux result
    logic [7:0]  addr;    // Byte address
    logic [2:0]  mux_pin; // Pin index of a mux write
    logic [3:0]  mux_fn;  // Function of a mux write

    assign addr    = apb_req.paddr;
    assign mux_pin = apb_req.pwdata[`GP_MUX_PIN_LSB +: 3];
    assign mux_fn  = apb_req.pwdata[`GP_MUX_FUNC_LSB +: 4];

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode: one wait state, so the answer is a flop
    // The registered answer costs a cycle per access but keeps the read mux
    // off the bus return path; a write lands only at the edge where pready
    // is seen high, so the access phase always spans two edges
    always_comb begin
        wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite & s.rsp.pready;
        rd_req = apb_req.psel & apb_req.penable & ~s.rsp.pready;
        hit    = 1'b1;
        rdval  = 32'h0000_0000;
        // Upper bits stay zero on byte-wide reads
        if (addr == `GP_OFF_SEL) begin
            rdval[7:0] = s.sel;
        end else if (addr == `GP_OFF_LEVEL) begin
            rdval[7:0] = s.sync2 & s.sel;
        end else if (addr == `GP_OFF_INT_EN || addr == `GP_OFF_INT_DIS) begin
            // Enable and disable both read back the unmask bits
            rdval[7:0] = s.unmask;
        end else if (addr == `GP_OFF_INT_CLR) begin
            rdval = 32'h0000_0000;
        end else if (addr == `GP_OFF_INT_STAT) begin
            rdval[7:0] = s.view ? (s.raw & s.unmask) : s.raw;
        end else if (addr == `GP_OFF_VIEW) begin
            rdval[0] = s.view;
        end else if (addr == `GP_OFF_DIR) begin
            rdval[15:0] = s.dir;
        end else if (addr == `GP_OFF_ITYPE) begin
            rdval[23:0] = s.itype;
        end else if (addr == `GP_OFF_PAD) begin
            rdval[15:0] = s.pad;
        end else if (addr == `GP_OFF_DOUT) begin
            rdval[7:0] = s.dout;
        end else if (addr == `GP_OFF_MUX) begin
            rdval = s.func;
        end else begin
            // Unmapped: error answer with zero data
            hit = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_s       = s;
        ev           = 8'h00;
        clr          = 8'h00;
        // Synchroniser: first stage feeds only the second
        // Pads are asynchronous, so no logic may read the first stage
        next_s.sync1 = pin_in;
        next_s.sync2 = s.sync1;
        next_s.prev  = s.sync2;
        // Detection per pin on synchronised levels
        // Limitation: a pin that idles high gives one rising edge after reset,
        // since the history flops start low
        for (int i = 0; i < 8; i++) begin
            case (s.itype[i])
                GP_FALL: ev[i] = ~s.sync2[i] & s.prev[i];
                GP_RISE: ev[i] = s.sync2[i] & ~s.prev[i];
                GP_BOTH: ev[i] = s.sync2[i] ^ s.prev[i];
                GP_LOW:  ev[i] = ~s.sync2[i];
                GP_HIGH: ev[i] = s.sync2[i];
                default: ev[i] = 1'b0;
            endcase
        end
        // Answer phase lasts exactly one cycle
        // prdata keeps its last value between answers, which saves a mux
        next_s.rsp.pready  = 1'b0;
        next_s.rsp.pslverr = 1'b0;
        if (rd_req) begin
            next_s.rsp.pready  = 1'b1;
            next_s.rsp.pslverr = ~hit;
            next_s.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : rdval;
        end
        // Writes take effect at the completing edge
        if (wr_acc) begin
            if (addr == `GP_OFF_SEL) begin
                next_s.sel = apb_req.pwdata[7:0];
            end else if (addr == `GP_OFF_INT_EN) begin
                next_s.unmask = s.unmask | s.sel;
            end else if (addr == `GP_OFF_INT_DIS) begin
                next_s.unmask = s.unmask & ~s.sel;
            end else if (addr == `GP_OFF_INT_CLR) begin
                // Clear acts on the selected pins, not on the write data
                clr = s.sel;
            end else if (addr == `GP_OFF_VIEW) begin
                next_s.view = apb_req.pwdata[0];
            end else if (addr == `GP_OFF_DOUT) begin
                next_s.dout = (s.dout & ~s.sel) | (apb_req.pwdata[7:0] & s.sel);
            end else if (addr == `GP_OFF_MUX) begin
                // One code per write, one function slot per pin
                // A code of zero leaves the pin as plain GPIO
                next_s.func[mux_pin*4 +: 4] = mux_fn;
            end
            for (int i = 0; i < 8; i++) begin
                // Reserved codes are dropped so the enums never hold an illegal value
                if (s.sel[i] && addr == `GP_OFF_DIR && apb_req.pwdata[1:0] <= 2'h2) begin
                    next_s.dir[i] = gp_dir_t'(apb_req.pwdata[1:0]);
                end
                if (s.sel[i] && addr == `GP_OFF_ITYPE && apb_req.pwdata[2:0] <= 3'h4) begin
                    next_s.itype[i] = gp_itype_t'(apb_req.pwdata[2:0]);
                end
                // Analog only prepares a pin that already has a function
                if (s.sel[i] && addr == `GP_OFF_PAD && apb_req.pwdata[1:0] <= 2'h2
                    && (apb_req.pwdata[1:0] != 2'h2 || s.func[i*4 +: 4] != 4'h0)) begin
                    next_s.pad[i] = gp_pad_t'(apb_req.pwdata[1:0]);
                end
            end
        end
        // A new event beats a clear in the same cycle
        // Level types set raw again every cycle, so clearing a held level does not stick
        next_s.raw = (s.raw & ~clr) | ev;
        // Request holds until pending bits really go
        // One cycle behind the pending bits, which keeps the output a plain flop
        next_s.irq = |(s.raw & s.unmask);
        // Pad drive per pin
        // Drives follow the configuration one cycle later, through flops
        for (int i = 0; i < 8; i++) begin
            logic v;
            logic e;
            v = 1'b0;
            e = 1'b0;
            case (s.dir[i])
                GP_DIR_OUT: begin
                    v = s.dout[i];
                    e = 1'b1;
                end
                GP_DIR_HW: begin
                    v = periph_out[i];
                    e = periph_oe[i];
                end
                default: begin
                    v = 1'b0;
                    e = 1'b0;
                end
            endcase
            case (s.pad[i])
                GP_OPEN_DRAIN: begin
                    next_s.pout[i] = 1'b0;
                    next_s.poe[i]  = e & ~v;
                end
                GP_ANALOG: begin
                    next_s.pout[i] = 1'b0;
                    next_s.poe[i]  = 1'b0;
                end
                default: begin
                    next_s.pout[i] = v;
                    next_s.poe[i]  = e;
                end
            endcase
            // Flag kept as a flop so the analog output is registered
            next_s.aen[i] = (next_s.pad[i] == GP_ANALOG);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    // Function codes reset to zero: every pin starts as plain GPIO
    // Only constants in the reset branch, so reset needs no clock
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s        <= '0;
            s.func   <= `GP_RST_FUNC;
            s.unmask <= `GP_RST_BYTE;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flops
    // Nothing is decoded here, so no pad or bus line sees a glitch
    always_comb begin
        apb_rsp   = s.rsp;
        pin_out   = s.pout;
        pin_oe    = s.poe;
        periph_in = s.sync2;
        alt_func  = s.func;
        irq       = s.irq;
        analog_en = s.aen;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    // Bus answers and register updates

    chk_level_read: assert property (
        rd_req && !apb_req.pwrite && addr == `GP_OFF_LEVEL
        |=> apb_rsp.prdata == {24'h0, $past(s.sync2 & s.sel)})
        else $error("level read wrong");
    chk_unmask_set: assert property (
        wr_acc && addr == `GP_OFF_INT_EN |=> s.unmask == $past(s.unmask | s.sel))
        else $error("enable wrong");
    chk_unmask_clear: assert property (
        wr_acc && addr == `GP_OFF_INT_DIS |=> s.unmask == $past(s.unmask & ~s.sel))
        else $error("disable wrong");
    chk_pending_clear: assert property (
        wr_acc && addr == `GP_OFF_INT_CLR && ev == 8'h00
        |=> (s.raw & $past(s.sel)) == 8'h00 && (s.raw & ~$past(s.sel)) == $past(s.raw & ~s.sel))
        else $error("clear wrong");
    chk_status_view: assert property (
        rd_req && !apb_req.pwrite && addr == `GP_OFF_INT_STAT
        |=> apb_rsp.prdata[7:0] == ($past(s.view) ? $past(s.raw & s.unmask) : $past(s.raw)))
        else $error("status view wrong");
    chk_irq_level: assert property (
        irq == $past(|(s.raw & s.unmask)))
        else $error("request mismatch");
    chk_mux_write: assert property (
        wr_acc && addr == `GP_OFF_MUX |=> alt_func[$past(mux_pin)*4 +: 4] == $past(mux_fn))
        else $error("mux write wrong");
    chk_analog_guard: assert property (
        wr_acc && addr == `GP_OFF_PAD && s.func[3:0] == 4'h0 |=> !analog_en[0] || $past(analog_en[0]))
        else $error("analog on unrouted pin");
    chk_answer_once: assert property (
        apb_rsp.pready |=> !apb_rsp.pready)
        else $error("answer too long");

    // Pad drive follows the configuration one edge later
    chk_out_drive: assert property (
        s.dir[0] == GP_DIR_OUT && s.pad[0] == GP_PUSH_PULL
        |=> pin_oe[0] && pin_out[0] == $past(s.dout[0]))
        else $error("output drive wrong");
    chk_hw_drive: assert property (
        s.dir[0] == GP_DIR_HW && s.pad[0] == GP_PUSH_PULL
        |=> pin_oe[0] == $past(periph_oe[0]) && pin_out[0] == $past(periph_out[0]))
        else $error("peripheral drive wrong");
    // An analog pad is never driven
    chk_analog_quiet: assert property (
        (pin_oe & $past(analog_en)) == 8'h00)
        else $error("analog pad driven");

    // A new event is never lost to a clear in the same cycle
    chk_event_sets: assert property (
        ev != 8'h00 |=> (s.raw & $past(ev)) == $past(ev))
        else $error("event lost");

    // Main scenarios
    cov_irq_rise:  cover property ($rose(irq));
    cov_irq_clear: cover property (wr_acc && addr == `GP_OFF_INT_CLR ##[1:4] $fell(irq));
    cov_mux_write: cover property (wr_acc && addr == `GP_OFF_MUX);
    cov_unmapped:  cover property (apb_rsp.pslverr);
    cov_hw_mode:   cover property (s.dir[0] == GP_DIR_HW && pin_oe[0]);
endmodule : gp_port
`default_nettype wire

//--- dv/gp_pins_model.sv
`timescale 1ns/100ps
`default_nettype none
module gp_pins_model (
    input  wire logic [7:0] ext_level,  // Level the outside world drives
    input  wire logic [7:0] pin_out,    // Port drive value
    input  wire logic [7:0] pin_oe,     // Port drive enable
    output logic      [7:0] pin_in,     // Resolved pad level
    output logic      [7:0] periph_out, // Peripheral drive value
    output logic      [7:0] periph_oe   // Peripheral drive enable
);
    // A driven pad shows the port value, an undriven one the outside level
    assign pin_in     = (pin_oe & pin_out) | (~pin_oe & ext_level);
    // Peripheral value differs from the pad so a wrong route is visible;
    // it drives wherever the outside level is high, so hardware mode shows
    assign periph_out = ~ext_level;
    assign periph_oe  = ext_level;
endmodule : gp_pins_model
`default_nettype wire

//--- dv/gp_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "gp_defs.svh"
module gp_port_tb;
    import gp_pkg::*;
    logic           clock;         // System clock
    logic           arst_n;        // Reset, active low
    gp_apb_req_t    req;           // APB request
    gp_apb_rsp_t    rsp;           // APB answer
    logic [7:0]     pin_in, pin_out, pin_oe, periph_out, periph_oe, periph_in, analog_en;
    logic [7:0]     ext;           // Outside pad levels
    logic [31:0]    alt_func;      // Function codes
    logic           irq;           // Interrupt request
    logic [31:0]    rd;            // Last read data
    logic           err;           // Last error flag
    int             errors;        // Mismatch count
    int             total_checks;  // Comparison count

    gp_port DUT (.clock(clock), .arst_n(arst_n), .apb_req(req), .apb_rsp(rsp),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .periph_out(periph_out),
        .periph_oe(periph_oe), .periph_in(periph_in), .alt_func(alt_func),
        .analog_en(analog_en), .irq(irq));
    gp_pins_model pads (.ext_level(ext), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_in(pin_in), .periph_out(periph_out), .periph_oe(periph_oe));

    ////////////////////////////////////////////////////////////////////////
    // Compare one word and count it
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; request held until pready is seen at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clock);
        req.penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h0, 32'h1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    // Select pins, then issue one write
    task sw(input logic [7:0] sel, input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, `GP_OFF_SEL, {24'h0, sel});
        apb(1'b1, a, d);
    endtask : sw

    task stop_test;
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////
    // Everything masked and nothing pending out of reset
    task t_reset;
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, `GP_OFF_INT_EN, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `GP_OFF_INT_STAT, 32'h0);
        chk(rd, 32'h0);
    endtask : t_reset

    // Outputs and inputs read alike, unselected bits zero
    task t_level;
        ext <= 8'h3C;
        sw(8'h03, `GP_OFF_DIR, 32'h1);
        apb(1'b1, `GP_OFF_DOUT, 32'h01);
        repeat (2) @(posedge clock);
        chk({16'h0, pin_oe, pin_out}, 32'h0301);
        sw(8'hA5, `GP_OFF_LEVEL, 32'hFF);
        repeat (4) @(posedge clock);
        apb(1'b0, `GP_OFF_LEVEL, 32'h0);
        chk({24'h0, rd[7:0]}, 32'h25);
        sw(8'h01, `GP_OFF_PAD, 32'h1);
        repeat (2) @(posedge clock);
        chk({16'h0, pin_oe, pin_out}, 32'h0200);
    endtask : t_level

    // Raw and masked status, enable, disable, clear, request level
    task t_irq;
        sw(8'hFF, `GP_OFF_DIR, 32'h0);
        apb(1'b1, `GP_OFF_ITYPE, 32'h1);
        ext <= 8'h00;
        repeat (6) @(posedge clock);
        apb(1'b1, `GP_OFF_INT_CLR, 32'h0);
        ext <= 8'h09;
        repeat (6) @(posedge clock);
        apb(1'b0, `GP_OFF_INT_STAT, 32'h0);
        chk({24'h0, rd[7:0]}, 32'h09);
        chk({31'h0, irq}, 32'h0);
        sw(8'h01, `GP_OFF_INT_EN, 32'h0);
        apb(1'b1, `GP_OFF_VIEW, 32'h1);
        apb(1'b0, `GP_OFF_INT_STAT, 32'h0);
        chk({24'h0, rd[7:0]}, 32'h01);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, `GP_OFF_INT_DIS, 32'h0);
        repeat (3) @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, `GP_OFF_INT_EN, 32'h0);
        sw(8'h08, `GP_OFF_INT_CLR, 32'h0);
        apb(1'b1, `GP_OFF_VIEW, 32'h0);
        apb(1'b0, `GP_OFF_INT_STAT, 32'h0);
        chk({24'h0, rd[7:0]}, 32'h01);
        chk({31'h0, irq}, 32'h1);
        sw(8'h01, `GP_OFF_INT_CLR, 32'h0);
        repeat (3) @(posedge clock);
        chk({31'h0, irq}, 32'h0);
    endtask : t_irq

    // Pin mux, analog type and an unmapped address
    task t_mux;
        apb(1'b1, `GP_OFF_MUX, 32'h52);
        @(posedge clock);
        chk(alt_func, 32'h0000_0500);
        apb(1'b1, `GP_OFF_MUX, 32'h32);
        @(posedge clock);
        chk(alt_func, 32'h0000_0300);
        sw(8'h06, `GP_OFF_PAD, 32'h2);
        @(posedge clock);
        chk({24'h0, analog_en}, 32'h04);
        apb(1'b0, 8'h30, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask : t_mux

    // Every detection type and direction code reads back
    task t_modes;
        for (int k = 0; k < 5; k++) begin
            sw(8'h01, `GP_OFF_ITYPE, k);
            apb(1'b0, `GP_OFF_ITYPE, 32'h0);
            chk({29'h0, rd[2:0]}, k);
        end
        apb(1'b1, `GP_OFF_PAD, 32'h0);
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, `GP_OFF_DIR, k);
            apb(1'b0, `GP_OFF_DIR, 32'h0);
            chk({30'h0, rd[1:0]}, k);
        end
        repeat (4) @(posedge clock);
        chk({30'h0, pin_oe[0], pin_out[0]}, 32'h2);
        chk({24'h0, periph_in}, 32'h08);
    endtask : t_modes

    ////////////////////////////////////////////////////////////////////////
    // Clock, free running at 100 MHz
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Hang guard
    initial begin
        #200us;
        errors++;
        stop_test;
    end

    // Main sequence
    initial begin
        errors = 0;
        total_checks = 0;
        arst_n = 1'b0;
        req = '0;
        ext = 8'h00;
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        t_reset;
        t_level;
        t_irq;
        t_mux;
        t_modes;
        stop_test;
    end
endmodule : gp_port_tb
`default_nettype wire
